/* File: verilog/mpc_pkg.sv */
/*
 * mpc_pkg: constants for the mode and port control block.
 * assumes: apb slave with 32-bit data, one clock pclk at 100 mhz.
 */
package mpc_pkg;
	// ==================================================
	// register byte offsets
	localparam logic [7:0] OFF_PORT_A_DATA = 8'h00;
	localparam logic [7:0] OFF_PORT_A_DIR  = 8'h04;
	localparam logic [7:0] OFF_PORT_B_DATA = 8'h08;
	localparam logic [7:0] OFF_PORT_B_DIR  = 8'h0c;
	localparam logic [7:0] OFF_PORT_B_ALT  = 8'h10;
	localparam logic [7:0] OFF_STATUS_WORD = 8'h14;
	localparam logic [7:0] OFF_HALT_EN     = 8'h18;
	localparam logic [7:0] OFF_STATUS      = 8'h1c;
	localparam logic [7:0] OFF_ACCESS      = 8'h20;
	// ==================================================
	// status word fields
	localparam int SW_EXT_ADDR   = 0;
	localparam int SW_WAIT_LO    = 1;
	localparam int SW_HALT       = 3;
	localparam int SW_IDLE       = 4;
	// access register fields: [15:0] address, 16 write, 17 byte-high
	localparam int ACC_WRITE     = 16;
	localparam int ACC_HIGH      = 17;
	// ==================================================
	// address map
	localparam logic [15:0] ROM_LO      = 16'he000;
	localparam logic [15:0] RAM_HI      = 16'h01ff;
	// ==================================================
	// port b pins taken by the external bus
	localparam int PB_LATCH   = 10;
	localparam int PB_WRITE   = 11;
	localparam int PB_HIGH    = 12;
	localparam int PB_READ    = 15;
	localparam logic [15:0] PB_BUS_MASK = 16'h9c00;
	// ==================================================
	// reset values
	localparam logic [15:0] RST_DIR  = 16'h0000;
	localparam logic [15:0] RST_DATA = 16'h0000;
	localparam logic [15:0] RST_ALT  = 16'h0000;
	localparam logic [4:0]  RST_SW   = 5'h00;
	// clocks after release before the bus-width strap is trusted
	localparam logic [1:0]  STRAP_SYNC = 2'h2;
	// ==================================================
	// base timer: system clock / 16
	localparam logic [3:0] TIMER_PRESCALE = 4'hf;
	typedef enum logic [4:0] {
		BUS_IDLE  = 5'b00001,
		BUS_ADDR  = 5'b00010,
		BUS_STRB  = 5'b00100,
		BUS_WAIT  = 5'b01000,
		BUS_DONE  = 5'b10000
	} mpc_bus_t;
endpackage : mpc_pkg

/* File: verilog/mpc_mode_port.sv */
/*
 * mpc_mode_port: operating-mode decode, ports a/b, external bus strobes,
 * wait states, ready stretching, halt and idle power save.
 * assumes: apb master on pclk; pins are asynchronous and synchronised here;
 * the pad logic resolves each pin from out and oe_n.
 */
`timescale 1ns/1ps
module mpc_mode_port (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rom_external_select_pin,
	input  wire logic        ready_in,
	input  wire logic        nmi_in,
	input  wire logic [15:0] port_a_in,
	output logic      [15:0] port_a_out,
	output logic      [15:0] port_a_oe_n,
	input  wire logic [15:0] port_b_in,
	output logic      [15:0] port_b_out,
	output logic      [15:0] port_b_oe_n,
	input  wire logic [15:0] port_b_alt_out,
	output logic             rom_select,
	output logic             illegal_access_fault_out,
	output logic             illegal_access_fault_oe_n,
	output logic             core_clock_run,
	output logic             halted,
	output logic             idling
);
	// ==================================================
	// state
	typedef struct packed {
		logic [1:0]       sa0, sa1, sn;
		logic [15:0]      a0, a1, b0, b1;
		logic [15:0]      a_data, a_dir, b_data, b_dir, b_alt;
		logic [4:0]       processor_status_word;
		logic             halt_en, halt_en_locked;
		logic             bus8, strap_done;
		logic [1:0]       strap_cnt;
		logic             fault;
		logic             nmi_q;
		logic [3:0]       pre;
		logic [15:0]      timer;
		mpc_pkg::mpc_bus_t bus;
		logic [15:0]      addr;
		logic             wr, hi, ext;
		logic [1:0]       wcnt;
		logic             ale, rd_n, wr_n, high_byte_strobe_n, drive_a;
		logic [15:0]      a_bus;
	} mpc_state_t;

	mpc_state_t q, next_q;

	// synchronised views; sa bit0 = rom pin, bit1 = ready; sn bit1 = nmi
	logic [15:0] pa, pb;
	logic        pin_rom, pin_rdy, pin_nmi;
	logic        setup, access, ext_mode, legal, off_chip;
	logic [15:0] rd_a, rd_b;
	logic [15:0] acc_addr;
	logic [1:0]  wait_sel;

	assign pa      = q.a1;
	assign pb      = q.b1;
	assign pin_rom = q.sa1[0];
	assign pin_rdy = q.sa1[1];
	assign pin_nmi = q.sn[1];
	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign acc_addr = pwdata[15:0];
	assign ext_mode = q.processor_status_word[mpc_pkg::SW_EXT_ADDR] || pin_rom;
	assign wait_sel = q.processor_status_word[mpc_pkg::SW_WAIT_LO +: 2];

	// ==================================================
	// address decode
	always_comb begin
		legal    = 1'b1;
		off_chip = 1'b0;
		if (acc_addr <= mpc_pkg::RAM_HI) begin
			off_chip = 1'b0;
		end else if (acc_addr >= mpc_pkg::ROM_LO) begin
			off_chip = pin_rom;
		end else begin
			legal    = q.processor_status_word[mpc_pkg::SW_EXT_ADDR];
			off_chip = q.processor_status_word[mpc_pkg::SW_EXT_ADDR];
		end
	end

	// read-back: input pins show the synchronised level, outputs the data register
	assign rd_a = (q.a_dir & q.a_data) | (~q.a_dir & pa);
	assign rd_b = (q.b_dir & q.b_data) | (~q.b_dir & pb);

	// ==================================================
	// next state
	always_comb begin
		next_q = q;
		next_q.sa0 = {ready_in, rom_external_select_pin};
		next_q.sa1 = q.sa0;
		next_q.sn  = {q.sn[0], nmi_in};
		next_q.a0  = port_a_in;
		next_q.a1  = q.a0;
		next_q.b0  = port_b_in;
		next_q.b1  = q.b0;
		next_q.nmi_q = pin_nmi;
		// strap waits until the pin has crossed both sync flops; earlier it reads reset zeros
		if (!q.strap_done) begin
			if (q.strap_cnt == mpc_pkg::STRAP_SYNC) begin
				next_q.strap_done = 1'b1;
				next_q.bus8       = pb[mpc_pkg::PB_HIGH];
			end else begin
				next_q.strap_cnt = q.strap_cnt + 2'h1;
			end
		end
		// base timer runs except in halt
		if (!q.processor_status_word[mpc_pkg::SW_HALT]) begin
			next_q.pre = q.pre + 4'h1;
			if (q.pre == mpc_pkg::TIMER_PRESCALE) begin
				next_q.timer = q.timer + 16'h0001;
				if (q.timer == 16'hffff && q.processor_status_word[mpc_pkg::SW_IDLE]) begin
					next_q.processor_status_word[mpc_pkg::SW_IDLE] = 1'b0;
				end
			end
		end
		// nmi rising edge wakes halt or idle
		if (pin_nmi && !q.nmi_q) begin
			next_q.processor_status_word[mpc_pkg::SW_HALT] = 1'b0;
			next_q.processor_status_word[mpc_pkg::SW_IDLE] = 1'b0;
		end
		// apb writes, one cycle after setup
		if (access && pwrite && !halted && !idling) begin
			unique case (paddr)
				mpc_pkg::OFF_PORT_A_DATA: next_q.a_data = pwdata[15:0];
				mpc_pkg::OFF_PORT_A_DIR:  next_q.a_dir  = pwdata[15:0];
				mpc_pkg::OFF_PORT_B_DATA: next_q.b_data = pwdata[15:0];
				mpc_pkg::OFF_PORT_B_DIR:  next_q.b_dir  = pwdata[15:0];
				mpc_pkg::OFF_PORT_B_ALT:  next_q.b_alt  = pwdata[15:0];
				mpc_pkg::OFF_STATUS_WORD: begin
					next_q.processor_status_word[2:0] = pwdata[2:0];
					next_q.processor_status_word[mpc_pkg::SW_IDLE] = pwdata[mpc_pkg::SW_IDLE];
					// halt only if enabled
					next_q.processor_status_word[mpc_pkg::SW_HALT] = pwdata[mpc_pkg::SW_HALT] && q.halt_en;
				end
				mpc_pkg::OFF_HALT_EN: begin
					if (!q.halt_en_locked) begin
						next_q.halt_en = pwdata[0];
						next_q.halt_en_locked = 1'b1;
					end
				end
				default: ;
			endcase
		end
		// fault latches on an illegal decoded access, cleared by any legal one
		if (setup && pwrite && paddr == mpc_pkg::OFF_ACCESS) begin
			next_q.fault = !legal;
		end
		// ==================================================
		// external bus cycle, started by a write to the access register
		unique case (q.bus)
			mpc_pkg::BUS_IDLE: begin
				if (setup && pwrite && paddr == mpc_pkg::OFF_ACCESS && !halted && !idling) begin
					next_q.addr = acc_addr;
					next_q.wr   = pwdata[mpc_pkg::ACC_WRITE];
					next_q.hi   = pwdata[mpc_pkg::ACC_HIGH];
					next_q.ext  = off_chip && legal && ext_mode;
					next_q.bus  = mpc_pkg::BUS_ADDR;
				end
			end
			mpc_pkg::BUS_ADDR: begin
				next_q.ale     = q.ext;
				next_q.drive_a = q.ext;
				next_q.a_bus   = q.addr;
				next_q.high_byte_strobe_n = !(q.ext && !q.bus8 && q.hi);
				next_q.wcnt    = wait_sel;
				next_q.bus     = mpc_pkg::BUS_STRB;
			end
			mpc_pkg::BUS_STRB: begin
				next_q.ale   = 1'b0;
				next_q.rd_n  = !(q.ext && !q.wr);
				next_q.wr_n  = !(q.ext && q.wr);
				next_q.drive_a = q.ext && q.wr;
				next_q.a_bus = q.wr ? q.a_data : q.addr;
				next_q.bus   = mpc_pkg::BUS_WAIT;
			end
			mpc_pkg::BUS_WAIT: begin
				if (q.wcnt != 2'h0) begin
					next_q.wcnt = q.wcnt - 2'h1;
				end else if (pin_rdy || !q.ext) begin
					next_q.bus = mpc_pkg::BUS_DONE;
				end
			end
			mpc_pkg::BUS_DONE: begin
				next_q.rd_n    = 1'b1;
				next_q.wr_n    = 1'b1;
				next_q.high_byte_strobe_n = 1'b1;
				next_q.drive_a = 1'b0;
				next_q.bus     = mpc_pkg::BUS_IDLE;
			end
			default: next_q.bus = mpc_pkg::BUS_IDLE;
		endcase
	end

	// ==================================================
	// registers; reset clears direction so every pin starts tri-stated
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q        <= '0;
			q.a_dir  <= mpc_pkg::RST_DIR;
			q.b_dir  <= mpc_pkg::RST_DIR;
			q.a_data <= mpc_pkg::RST_DATA;
			q.b_data <= mpc_pkg::RST_DATA;
			q.b_alt  <= mpc_pkg::RST_ALT;
			q.processor_status_word <= mpc_pkg::RST_SW;
			q.bus    <= mpc_pkg::BUS_IDLE;
			q.rd_n   <= 1'b1;
			q.wr_n   <= 1'b1;
			q.high_byte_strobe_n <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// ==================================================
	// apb answer: zero wait; a write to the access register stalls until the bus cycle ends
	always_comb begin
		pready  = 1'b1;
		pslverr = 1'b0;
		if (access && paddr == mpc_pkg::OFF_ACCESS && pwrite) begin
			pready = (q.bus == mpc_pkg::BUS_DONE);
		end
		if (access && paddr > mpc_pkg::OFF_ACCESS) begin
			pslverr = 1'b1;
		end
	end

	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			mpc_pkg::OFF_PORT_A_DATA: prdata[15:0] = rd_a;
			mpc_pkg::OFF_PORT_A_DIR:  prdata[15:0] = q.a_dir;
			mpc_pkg::OFF_PORT_B_DATA: prdata[15:0] = rd_b;
			mpc_pkg::OFF_PORT_B_DIR:  prdata[15:0] = q.b_dir;
			mpc_pkg::OFF_PORT_B_ALT:  prdata[15:0] = q.b_alt;
			mpc_pkg::OFF_STATUS_WORD: prdata[4:0]  = q.processor_status_word;
			mpc_pkg::OFF_HALT_EN:     prdata[1:0]  = {q.halt_en_locked, q.halt_en};
			mpc_pkg::OFF_STATUS:      prdata[3:0]  = {q.bus8, ext_mode, pin_rom, q.fault};
			mpc_pkg::OFF_ACCESS:      prdata[15:0] = q.addr;
			default:                  prdata = 32'h0000_0000;
		endcase
	end

	// ==================================================
	// pins; port b mixes gpio, alternate function and bus strobes
	logic [15:0] b_gp, b_strobe;
	always_comb begin
		b_gp = (q.b_alt & port_b_alt_out) | (~q.b_alt & q.b_data);
		b_strobe = b_gp;
		b_strobe[mpc_pkg::PB_LATCH] = q.ale;
		b_strobe[mpc_pkg::PB_WRITE] = q.wr_n;
		b_strobe[mpc_pkg::PB_HIGH]  = q.high_byte_strobe_n;
		b_strobe[mpc_pkg::PB_READ]  = q.rd_n;
	end

	// external modes hand port a and the strobe pins to the bus
	assign port_a_out  = ext_mode ? q.a_bus : q.a_data;
	assign port_a_oe_n = ext_mode ? {16{!q.drive_a}} : ~q.a_dir;
	assign port_b_out  = ext_mode ? b_strobe : b_gp;
	// strobe pins tri-stated until the strap is taken, then driven
	logic [15:0] pb_bus_drv;
	assign pb_bus_drv  = q.strap_done ? mpc_pkg::PB_BUS_MASK : 16'h0000;
	assign port_b_oe_n = ext_mode ? (~q.b_dir & ~pb_bus_drv) : ~q.b_dir;
	assign rom_select  = !pin_rom;
	// open drain: pull low only while faulting
	assign illegal_access_fault_out  = 1'b0;
	assign illegal_access_fault_oe_n = !q.fault;
	assign halted         = q.processor_status_word[mpc_pkg::SW_HALT];
	assign idling         = q.processor_status_word[mpc_pkg::SW_IDLE];
	assign core_clock_run = !(halted || idling);

	// ==================================================
	// checks
	property p_fault_on_illegal;
		@(posedge pclk) disable iff (!presetn)
		(setup && pwrite && paddr == mpc_pkg::OFF_ACCESS && !legal) |=> !illegal_access_fault_oe_n;
	endproperty
	a_fault_on_illegal: assert property (p_fault_on_illegal) else $error("fault not raised");

	property p_no_fault_ext;
		@(posedge pclk) disable iff (!presetn)
		(setup && pwrite && paddr == mpc_pkg::OFF_ACCESS && q.processor_status_word[mpc_pkg::SW_EXT_ADDR])
			|=> illegal_access_fault_oe_n;
	endproperty
	a_no_fault_ext: assert property (p_no_fault_ext) else $error("fault in extended mode");

	property p_input_tristate;
		@(posedge pclk) disable iff (!presetn)
		!ext_mode |-> (port_a_oe_n == ~q.a_dir);
	endproperty
	a_input_tristate: assert property (p_input_tristate) else $error("port a drive wrong");

	property p_strobe_internal;
		@(posedge pclk) disable iff (!presetn)
		(q.bus == mpc_pkg::BUS_STRB && !q.ext) |=> (q.rd_n && q.wr_n);
	endproperty
	a_strobe_internal: assert property (p_strobe_internal) else $error("strobe on internal");

	sequence s_bus_start;
		q.bus == mpc_pkg::BUS_ADDR;
	endsequence
	property p_wait_states;
		@(posedge pclk) disable iff (!presetn)
		s_bus_start |=> (q.bus == mpc_pkg::BUS_STRB) ##0 (q.wcnt == $past(wait_sel));
	endproperty
	a_wait_states: assert property (p_wait_states) else $error("wait count wrong");

	property p_ready_stretch;
		@(posedge pclk) disable iff (!presetn)
		(q.bus == mpc_pkg::BUS_WAIT && q.wcnt == 2'h0 && q.ext && !pin_rdy) |=> q.bus == mpc_pkg::BUS_WAIT;
	endproperty
	a_ready_stretch: assert property (p_ready_stretch) else $error("cycle not stretched");

	property p_halt_lock;
		@(posedge pclk) disable iff (!presetn)
		q.halt_en_locked |=> (q.halt_en == $past(q.halt_en));
	endproperty
	a_halt_lock: assert property (p_halt_lock) else $error("halt enable changed twice");

	property p_halt_exit;
		@(posedge pclk) disable iff (!presetn)
		(halted && !(pin_nmi && !q.nmi_q)) |=> halted;
	endproperty
	a_halt_exit: assert property (p_halt_exit) else $error("halt left without nmi");

	property p_halt_timer;
		@(posedge pclk) disable iff (!presetn)
		halted ##1 halted |-> $stable(q.timer);
	endproperty
	a_halt_timer: assert property (p_halt_timer) else $error("timer ran in halt");

	property p_idle_timer;
		@(posedge pclk) disable iff (!presetn)
		(idling && !halted && q.pre == mpc_pkg::TIMER_PRESCALE) |=> (q.timer == $past(q.timer) + 16'h0001);
	endproperty
	a_idle_timer: assert property (p_idle_timer) else $error("base timer stopped in idle");

	property p_halt_gate;
		@(posedge pclk) disable iff (!presetn)
		(!q.halt_en && !halted) |=> !halted;
	endproperty
	a_halt_gate: assert property (p_halt_gate) else $error("halt entered while disabled");
endmodule : mpc_mode_port

/* File: verif/mpc_ext_mem.sv */
/*
 * mpc_ext_mem: external memory behind the multiplexed address/data bus.
 * assumes: the bench resolves pin levels; latch high, read/write/high strobes low.
 */
`timescale 1ns/1ps
module mpc_ext_mem (
	input  wire logic        pclk,
	input  wire logic [15:0] bus_lvl,
	input  wire logic [15:0] pb_lvl,
	input  wire logic [3:0]  stall,
	input  wire logic        clr,
	output logic      [15:0] bus_drive,
	output logic             ready,
	output logic      [15:0] last_addr,
	output logic      [2:0]  seen
);
	// ==================================================
	// storage and strobe tracking
	logic [15:0] mem [256];
	logic [15:0] last_drv;
	logic [3:0]  cnt;
	wire         act = !pb_lvl[15] || !pb_lvl[11];
	assign ready = (cnt >= stall);
	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
		last_drv = 16'h5a5a;
		bus_drive = 16'ha5a5;
		cnt = 4'h0;
		last_addr = 16'h0000;
		seen = 3'h0;
	end
	always @(posedge pclk) begin
		if (pb_lvl[10])
			last_addr <= bus_lvl;
		cnt <= act ? cnt + 4'h1 : 4'h0;
		seen <= clr ? 3'h0 : seen | {!pb_lvl[12], !pb_lvl[11], !pb_lvl[15]};
		if (!pb_lvl[11])
			mem[last_addr[7:0]] <= bus_lvl;
		// released bus shows the inverse of the last value, never a stale copy
		if (!pb_lvl[15]) begin
			bus_drive <= mem[last_addr[7:0]];
			last_drv <= mem[last_addr[7:0]];
		end else
			bus_drive <= ~last_drv;
	end
endmodule : mpc_ext_mem

/* File: verif/mpc_mode_port_tb.sv */
/*
 * mpc_mode_port_tb: directed bench for mode decode, ports and power save.
 * assumes: mpc_ext_mem on the bus, pull resistors on port b pins.
 */
`timescale 1ns/1ps
module mpc_mode_port_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rom_pin = 0, nmi = 0, clr = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, rom_select, fault, fault_oe_n, run, halted, idling, ready, slv;
	logic [15:0] pa_out, pa_oe_n, pb_out, pb_oe_n, ext_drive, last_addr, pb_pull = 16'hffff, alt = 0;
	logic [3:0] stall = 0;
	logic [2:0] seen;
	int err_total = 0, num_checks = 0, lat, prev, cyc = 0;
	wire [15:0] pa_lvl = (pa_out & ~pa_oe_n) | (ext_drive & pa_oe_n);
	wire [15:0] pb_lvl = (pb_out & ~pb_oe_n) | (pb_pull & pb_oe_n);
	always #5 pclk = ~pclk;
	mpc_mode_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rom_external_select_pin(rom_pin), .ready_in(ready), .nmi_in(nmi), .port_a_in(pa_lvl),
		.port_a_out(pa_out), .port_a_oe_n(pa_oe_n), .port_b_in(pb_lvl), .port_b_out(pb_out),
		.port_b_oe_n(pb_oe_n), .port_b_alt_out(alt), .rom_select(rom_select), .illegal_access_fault_out(fault),
		.illegal_access_fault_oe_n(fault_oe_n), .core_clock_run(run), .halted(halted), .idling(idling));
	mpc_ext_mem u_mem (.pclk(pclk), .bus_lvl(pa_lvl), .pb_lvl(pb_lvl), .stall(stall), .clr(clr),
		.bus_drive(ext_drive), .ready(ready), .last_addr(last_addr), .seen(seen));
	// ==================================================
	// shared tasks
	task automatic test_done();
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		lat = 0;
		do begin
			@(posedge pclk);
			lat++;
		end while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic acc(input logic hi, input logic w, input logic [15:0] a);
		@(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		apb(1'b1, mpc_pkg::OFF_ACCESS, {14'h0000, hi, w, a});
		repeat (3) @(posedge pclk);
	endtask : acc
	task automatic rst(input logic [15:0] pull);
		presetn <= 1'b0;
		pb_pull <= pull;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, mpc_pkg::OFF_STATUS, 32'h0);
	endtask : rst
	// ==================================================
	// scenarios
	task automatic sc_ports();
		apb(1'b0, mpc_pkg::OFF_PORT_A_DIR, 32'h0);
		chk("a_dir_rst", 32'h0, rd);
		chk("a_oe_rst", 32'hffff, {16'h0, pa_oe_n});
		chk("b_oe_rst", 32'hffff, {16'h0, pb_oe_n});
		apb(1'b1, mpc_pkg::OFF_PORT_A_DIR, 32'h00ff);
		apb(1'b1, mpc_pkg::OFF_PORT_A_DATA, 32'h1234);
		repeat (3) @(posedge pclk);
		chk("a_oe", 32'hff00, {16'h0, pa_oe_n});
		chk("a_out", 32'h34, {24'h0, pa_out[7:0]});
		apb(1'b0, mpc_pkg::OFF_PORT_A_DATA, 32'h0);
		chk("a_rd", {16'h0, pa_lvl[15:8], 8'h34}, rd);
		apb(1'b1, mpc_pkg::OFF_PORT_A_DIR, 32'hffff);
		repeat (3) @(posedge pclk);
		chk("a_held", 32'h1234, {16'h0, pa_out});
		alt <= 16'h0008;
		apb(1'b1, mpc_pkg::OFF_PORT_B_DIR, 32'h0008);
		apb(1'b1, mpc_pkg::OFF_PORT_B_ALT, 32'h0008);
		apb(1'b0, mpc_pkg::OFF_PORT_B_ALT, 32'h0);
		chk("b_alt_rd", 32'h0008, rd);
		chk("no_slverr", 32'h0, {31'h0, slv});
		chk("b_alt_pin", 32'h1, {31'h0, pb_out[3]});
		apb(1'b1, mpc_pkg::OFF_PORT_B_ALT, 32'h0);
		repeat (2) @(posedge pclk);
		chk("b_gpio_pin", 32'h0, {31'h0, pb_out[3]});
		apb(1'b0, 8'h24, 32'h0);
		chk("slverr", 32'h1, {31'h0, slv});
	endtask : sc_ports
	task automatic sc_map();
		acc(1'b0, 1'b1, 16'h0300);
		chk("fault_pin", 32'h0, {31'h0, fault_oe_n});
		chk("fault_lvl", 32'h0, {31'h0, fault});
		chk("int_strb", 32'h0, {29'h0, seen});
		acc(1'b0, 1'b0, 16'h0100);
		chk("ram_ok", 32'h1, {31'h0, fault_oe_n});
		acc(1'b0, 1'b0, 16'he000);
		chk("rom_sel", 32'h1, {31'h0, rom_select});
		prev = 0;
		for (int w = 0; w < 4; w++) begin
			apb(1'b1, mpc_pkg::OFF_STATUS_WORD, {29'h0, 2'(w), 1'b1});
			acc(1'b0, 1'b1, 16'h0300);
			chk("strb_drv", 32'h0, {16'h0, pb_oe_n & mpc_pkg::PB_BUS_MASK});
			chk("ext_wr", 32'h2, {29'h0, seen & 3'h2});
			chk("ext_addr", 32'h0300, {16'h0, last_addr});
			chk("no_fault", 32'h1, {31'h0, fault_oe_n});
			if (w > 0)
				chk("wait_grow", 32'h1, {31'h0, lat > prev});
			prev = lat;
		end
		apb(1'b1, mpc_pkg::OFF_STATUS_WORD, 32'h1);
		acc(1'b0, 1'b1, 16'h0300);
		prev = lat;
		stall <= 4'h4;
		acc(1'b0, 1'b1, 16'h0300);
		chk("ready_stretch", 32'h1, {31'h0, lat > prev});
		stall <= 4'h0;
		acc(1'b1, 1'b0, 16'h0400);
		chk("hi_rd", 32'h5, {29'h0, seen});
		acc(1'b0, 1'b0, 16'he000);
		chk("rom_int", 32'h0, {29'h0, seen});
		rom_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		acc(1'b0, 1'b0, 16'he000);
		chk("rom_ext", 32'h1, {29'h0, seen & 3'h1});
		chk("rom_sel_off", 32'h0, {31'h0, rom_select});
		apb(1'b1, mpc_pkg::OFF_STATUS_WORD, 32'h0);
		acc(1'b0, 1'b1, 16'h0300);
		chk("romless_fault", 32'h0, {31'h0, fault_oe_n});
		rom_pin <= 1'b0;
	endtask : sc_map
	task automatic sc_power();
		apb(1'b1, mpc_pkg::OFF_STATUS_WORD, 32'h08);
		repeat (4) @(posedge pclk);
		chk("halt_gated", 32'h0, {31'h0, halted});
		apb(1'b1, mpc_pkg::OFF_HALT_EN, 32'h1);
		apb(1'b1, mpc_pkg::OFF_HALT_EN, 32'h0);
		apb(1'b0, mpc_pkg::OFF_HALT_EN, 32'h0);
		chk("halt_en_once", 32'h1, {31'h0, rd[0]});
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, mpc_pkg::OFF_STATUS_WORD, m ? 32'h10 : 32'h08);
			repeat (20) @(posedge pclk);
			chk("save_mode", 32'h1, {31'h0, m ? idling : halted});
			chk("clk_stop", 32'h0, {31'h0, run});
			nmi <= 1'b1;
			repeat (8) @(posedge pclk);
			nmi <= 1'b0;
			chk("nmi_wake", 32'h0, {31'h0, halted | idling});
		end
		apb(1'b0, mpc_pkg::OFF_PORT_A_DATA, 32'h0);
		chk("retained", 32'h1234, rd);
	endtask : sc_power
	// ==================================================
	// main sequence and hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		rst(16'hffff);
		chk("bus8", 32'h1, {31'h0, rd[3]});
		rst(16'hefff);
		chk("bus16", 32'h0, {31'h0, rd[3]});
		// strap is taken; a low pull would read as a high-byte strobe later
		pb_pull <= 16'hffff;
		sc_ports();
		sc_map();
		sc_power();
		test_done();
	end
endmodule : mpc_mode_port_tb
